/* File: rtl/seq_dev.sv */
// Purpose: Device end: simultaneous hold and sequenced conversion of four channels
// Assumes: Host pins arrive asynchronously; conversion core is modelled by sampled inputs
// Notes:   Results queue in ascending channel order and are popped per read
`timescale 1ns/100ps
module seq_dev
  import seq_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  seq_if.dev                         link,
  input  wire sample_t               analog_in [NUM_CH],
  input  wire logic                  sw_sel_mode,
  input  wire logic                  sw_sel_we,
  input  wire logic [3:0]            sw_sel_data,
  output logic                       hold_q,
  output logic [3:0]                 sw_sel_q
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_CONV = 2'b01, S_NEXT = 2'b10
  } dstate_e;

  function automatic logic [2:0] first_ch(input logic [3:0] m);
    first_ch = 3'd4;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) first_ch = 3'(i);
    end
  endfunction : first_ch

  // Three-stage samplers; change accepted when stages two and three agree
  logic [2:0] cs_s_q, rd_s_q, st_s_q;
  logic [3:0] ch_s1_q, ch_s2_q, ch_s3_q;
  logic       rd_act_q, rd_act_d, start_f_q, start_f_d;
  logic [3:0] pins_sel_q, pins_sel_d;

  dstate_e          st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0]       todo_q, todo_d;
  logic [1:0]       ch_q, ch_d;
  sample_t          held_q [NUM_CH];
  sample_t          held_d [NUM_CH];
  sample_t          res_q [NUM_CH];
  sample_t          res_d [NUM_CH];
  logic [1:0]       wr_q, wr_d, rp_q, rp_d;
  logic [2:0]       cnt_res_q, cnt_res_d;
  logic             eoc_q, eoc_d, busy_q, busy_d, hold_d;
  sample_t          dout_q, dout_d;
  logic [3:0]       sw_sel_d;
  logic [3:0]       sel;
  logic             start_fall, rd_fall, pop, push;
  logic [2:0]       next_ch;

  always_comb begin
    rd_act_d   = (cs_s_q[2] == cs_s_q[1] && rd_s_q[2] == rd_s_q[1]) ?
                 (!cs_s_q[2] && !rd_s_q[2]) : rd_act_q;
    start_f_d  = (st_s_q[2] == st_s_q[1]) ? !st_s_q[2] : start_f_q;
    pins_sel_d = (ch_s2_q == ch_s3_q) ? ch_s3_q : pins_sel_q;
    sw_sel_d   = sw_sel_we ? sw_sel_data : sw_sel_q;
  end

  // Qualified pin value, so a mask set together with the start edge is seen in time
  assign sel        = sw_sel_mode ? sw_sel_q : pins_sel_d;
  assign next_ch    = first_ch(todo_q);
  assign start_fall = start_f_d && !start_f_q;
  assign rd_fall    = rd_act_d && !rd_act_q;
  assign pop        = rd_fall && cnt_res_q != 3'd0;

  // Sequencer timed by the local clock, no external conversion clock
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    todo_d = todo_q;
    ch_d   = ch_q;
    hold_d = hold_q;
    busy_d = busy_q;
    eoc_d  = 1'b0;
    push   = 1'b0;
    held_d = held_q;
    case (st_q)
      S_IDLE: begin
        if (start_fall && sel != 4'h0) begin
          held_d = analog_in;
          hold_d = 1'b1;
          busy_d = 1'b1;
          todo_d = sel;
          st_d   = S_NEXT;
        end
      end
      S_NEXT: begin
        if (next_ch == 3'd4) begin
          hold_d = 1'b0;
          busy_d = 1'b0;
          st_d   = S_IDLE;
        end else begin
          ch_d   = next_ch[1:0];
          cnt_d  = '0;
          st_d   = S_CONV;
        end
      end
      S_CONV: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(CONV_CYCLES - 1)) begin
          eoc_d  = 1'b1;
          push   = 1'b1;
          todo_d = todo_q & ~(4'h1 << ch_q);
          st_d   = S_NEXT;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Result queue in conversion order; reads may overlap conversions
  always_comb begin
    res_d     = res_q;
    wr_d      = wr_q;
    rp_d      = rp_q;
    cnt_res_d = cnt_res_q;
    dout_d    = dout_q;
    if (st_q == S_IDLE && start_fall && sel != 4'h0) begin
      wr_d      = 2'd0;
      rp_d      = 2'd0;
      cnt_res_d = 3'd0;
    end else begin
      if (push) begin
        res_d[wr_q] = held_q[ch_q];
        wr_d        = wr_q + 2'd1;
      end
      if (pop) begin
        dout_d = res_q[rp_q];
        rp_d   = rp_q + 2'd1;
      end
      cnt_res_d = cnt_res_q + 3'(push) - 3'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_q     <= 3'b111;
      rd_s_q     <= 3'b111;
      st_s_q     <= 3'b111;
      ch_s1_q    <= 4'h0;
      ch_s2_q    <= 4'h0;
      ch_s3_q    <= 4'h0;
      rd_act_q   <= 1'b0;
      start_f_q  <= 1'b0;
      pins_sel_q <= 4'h0;
      sw_sel_q   <= CH_SEL_RESET;
      st_q       <= S_IDLE;
      cnt_q      <= '0;
      todo_q     <= 4'h0;
      ch_q       <= 2'd0;
      hold_q     <= 1'b0;
      busy_q     <= 1'b0;
      eoc_q      <= 1'b0;
      wr_q       <= 2'd0;
      rp_q       <= 2'd0;
      cnt_res_q  <= 3'd0;
      dout_q     <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        held_q[i] <= '0;
        res_q[i]  <= '0;
      end
    end else begin
      cs_s_q     <= {cs_s_q[1:0], link.cs_n};
      rd_s_q     <= {rd_s_q[1:0], link.rd_n};
      st_s_q     <= {st_s_q[1:0], link.conversion_start_n};
      ch_s1_q    <= link.ch_sel;
      ch_s2_q    <= ch_s1_q;
      ch_s3_q    <= ch_s2_q;
      rd_act_q   <= rd_act_d;
      start_f_q  <= start_f_d;
      pins_sel_q <= pins_sel_d;
      sw_sel_q   <= sw_sel_d;
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      todo_q     <= todo_d;
      ch_q       <= ch_d;
      hold_q     <= hold_d;
      busy_q     <= busy_d;
      eoc_q      <= eoc_d;
      wr_q       <= wr_d;
      rp_q       <= rp_d;
      cnt_res_q  <= cnt_res_d;
      dout_q     <= dout_d;
      held_q     <= held_d;
      res_q      <= res_d;
    end
  end

  assign link.eoc_n    = !eoc_q;
  assign link.busy     = busy_q;
  assign link.data_out = dout_q;
  // Driving only while selected keeps the shared bus free for others
  assign link.data_oe  = rd_act_q;
endmodule : seq_dev

/* File: shared/seq_pkg.sv */
// Purpose: Shared constants for the simultaneous-sample conversion sequencer and its host
// Assumes: 40 MHz system clock
// Notes:   Timing counts derive from printed times
package seq_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned CONV_TIME_NS   = 1650;
  localparam int unsigned ACQ_TIME_NS    = 350;
  localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  // Least times round up to whole cycles
  localparam int unsigned CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACQ_CYCLES     = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Device pins pass a three-stage sampler, so read strobes stand several cycles
  localparam int unsigned RD_LOW_CYCLES  = 7;
  localparam int unsigned RD_GAP_CYCLES  = 7;
  localparam int unsigned DATA_W         = 12;
  localparam int unsigned NUM_CH         = 4;
  localparam int unsigned CNT_W          = 8;
  localparam logic [3:0]  CH_SEL_RESET   = 4'hF;
  typedef logic [DATA_W-1:0] sample_t;
endpackage : seq_pkg

/* File: shared/seq_if.sv */
// Purpose: Pins between converter sequencer and host
// Assumes: Single clock, pins active low where named _n
// Notes:   Data bus is driven only while chip select and read are low
`timescale 1ns/100ps
interface seq_if;
  import seq_pkg::*;
  logic       conversion_start_n;
  logic       cs_n;
  logic       rd_n;
  logic [3:0] ch_sel;
  logic       eoc_n;
  logic       busy;
  sample_t    data_out;
  logic       data_oe;
  sample_t    data;
  assign data = data_oe ? data_out : '0;
  modport dev  (input conversion_start_n, cs_n, rd_n, ch_sel,
                output eoc_n, busy, data_out, data_oe);
  modport host (output conversion_start_n, cs_n, rd_n, ch_sel,
                input eoc_n, busy, data);
endinterface : seq_if

/* File: rtl/seq_host.sv */
// Purpose: Host end: starts sequences, selects channels and reads results
// Assumes: Device on the same clock, pins pass a three-stage sampler
// Notes:   Reads after the sequence ends, then waits acquisition time
`timescale 1ns/100ps
module seq_host
  import seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  seq_if.host             link,
  input  wire logic       start_req,
  input  wire logic [3:0] ch_mask,
  output logic            start_ready,
  output sample_t         rd_data_q,
  output logic            rd_valid_q,
  output logic            seq_done_q
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_WAIT = 3'b010,
    H_READ = 3'b011, H_GAP = 3'b100, H_ACQ = 3'b101
  } hstate_e;

  function automatic logic [2:0] popcount4(input logic [3:0] m);
    popcount4 = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction : popcount4

  hstate_e          st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0]       left_q, left_d;
  logic [3:0]       mask_q, mask_d;
  logic [2:0]       busy_s_q;
  logic             rd_valid_d, seq_done_d;
  sample_t          rd_data_d;

  // Read-after-sequence mode
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    left_d     = left_q;
    mask_d     = mask_q;
    rd_valid_d = 1'b0;
    seq_done_d = 1'b0;
    rd_data_d  = rd_data_q;
    case (st_q)
      H_IDLE: begin
        if (start_req && ch_mask != 4'h0) begin
          mask_d = ch_mask;
          left_d = popcount4(ch_mask);
          cnt_d  = '0;
          st_d   = H_START;
        end
      end
      H_START: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(4)) begin
          cnt_d = '0;
          st_d  = H_WAIT;
        end
      end
      H_WAIT: begin
        // Saturate so a long sequence cannot wrap the counter
        if (cnt_q != '1) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (cnt_q > CNT_W'(8) && !busy_s_q[2] && !busy_s_q[1]) begin
          cnt_d = '0;
          st_d  = H_READ;
        end
      end
      H_READ: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(RD_LOW_CYCLES - 1)) begin
          rd_data_d  = link.data;
          rd_valid_d = 1'b1;
          left_d     = left_q - 1'b1;
          cnt_d      = '0;
          st_d       = H_GAP;
        end
      end
      H_GAP: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(RD_GAP_CYCLES - 1)) begin
          cnt_d = '0;
          st_d  = (left_q == 3'd0) ? H_ACQ : H_READ;
        end
      end
      H_ACQ: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(ACQ_CYCLES)) begin
          seq_done_d = 1'b1;
          st_d       = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= H_IDLE;
      cnt_q      <= '0;
      left_q     <= 3'd0;
      mask_q     <= 4'h0;
      busy_s_q   <= 3'b000;
      rd_valid_q <= 1'b0;
      seq_done_q <= 1'b0;
      rd_data_q  <= '0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      left_q     <= left_d;
      mask_q     <= mask_d;
      busy_s_q   <= {busy_s_q[1:0], link.busy};
      rd_valid_q <= rd_valid_d;
      seq_done_q <= seq_done_d;
      rd_data_q  <= rd_data_d;
    end
  end

  assign start_ready             = (st_q == H_IDLE);
  assign link.conversion_start_n = !(st_q == H_START);
  assign link.ch_sel             = mask_q;
  assign link.cs_n               = !(st_q == H_READ);
  assign link.rd_n               = !(st_q == H_READ);
endmodule : seq_host

/* File: tb/seq_props.sv */
// Purpose: Timing checks on the link between host and device ends
// Assumes: One clock; device reads its channel set from the pins
// Notes:   Windows allow for the device's input samplers
`timescale 1ns/100ps
module seq_props
  import seq_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       conversion_start_n,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic [3:0] ch_sel,
  input wire logic       eoc_n,
  input wire logic       busy,
  input wire logic       data_oe
);
  logic [7:0] gap_q;
  logic [2:0] eocs_q;
  logic [3:0] sel_q;
  logic [5:0] rd_hist_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= '0;
      eocs_q <= '0;
      sel_q <= '0;
      rd_hist_q <= '0;
    end else begin
      gap_q <= (!busy || !eoc_n) ? 8'h00 : gap_q + 8'(gap_q != 8'hFF);
      eocs_q <= busy ? eocs_q + 3'(!eoc_n) : 3'h0;
      sel_q <= busy ? sel_q : ch_sel;
      rd_hist_q <= {rd_hist_q[4:0], !cs_n && !rd_n};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  eoc_width_a: assert property ($fell(eoc_n) |=> eoc_n)
    else $error("eoc low longer than one cycle");
  eoc_busy_a: assert property (!eoc_n |-> busy)
    else $error("eoc outside a sequence");
  conv_gap_a: assert property ($fell(eoc_n) |->
    gap_q >= CONV_CYCLES && gap_q <= CONV_CYCLES + 4)
    else $error("conversion time off");
  busy_end_a: assert property ($fell(busy) |-> !$past(eoc_n))
    else $error("busy fell away from last eoc");
  start_hold_a: assert property (
    $fell(conversion_start_n) && !busy && ch_sel != 4'h0 |-> ##[3:5] busy)
    else $error("start not taken");
  eoc_count_a: assert property ($fell(busy) |-> eocs_q == $countones(sel_q))
    else $error("eoc count differs from selection");
  busy_min_a: assert property ($rose(busy) |=> busy[*8])
    else $error("busy too short");
  read_drive_a: assert property ($rose(data_oe) |-> rd_hist_q != 6'h00)
    else $error("bus driven without read");
endmodule : seq_props

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for host and device ends
// Assumes: 40 MHz clock, inputs driven on the falling edge
// Notes:   A second device is driven pin by pin, since the host reads only after a sequence
`timescale 1ns/100ps
module tb_top
  import seq_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       start_req = 1'b0;
  logic [3:0] ch_mask = 4'h0;
  logic       sw_mode = 1'b0;
  logic       sw_we = 1'b0;
  logic [3:0] sw_data = 4'h0;
  sample_t    ana1 [NUM_CH];
  sample_t    ana2 [NUM_CH];
  sample_t    rd_data;
  logic       start_ready, rd_valid, seq_done, hold1, hold2;
  logic [3:0] sel1, sel2;
  int         err_total = 0;
  int         check_count = 0;
  int         eocs1 = 0;
  int         eocs2 = 0;
  seq_if      if1 ();
  seq_if      if2 ();
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    eocs1 <= eocs1 + int'(if1.eoc_n === 1'b0);
    eocs2 <= eocs2 + int'(if2.eoc_n === 1'b0);
  end
  seq_host seq_host_inst (.clk(clk), .rst_n(rst_n), .link(if1.host), .start_req(start_req),
    .ch_mask(ch_mask), .start_ready(start_ready), .rd_data_q(rd_data),
    .rd_valid_q(rd_valid), .seq_done_q(seq_done));
  seq_dev seq_dev_inst (.clk(clk), .rst_n(rst_n), .link(if1.dev), .analog_in(ana1),
    .sw_sel_mode(1'b0), .sw_sel_we(1'b0), .sw_sel_data(4'h0), .hold_q(hold1), .sw_sel_q(sel1));
  seq_dev seq_dev_inst2 (.clk(clk), .rst_n(rst_n), .link(if2.dev), .analog_in(ana2),
    .sw_sel_mode(sw_mode), .sw_sel_we(sw_we), .sw_sel_data(sw_data), .hold_q(hold2),
    .sw_sel_q(sel2));
  seq_props seq_props_inst (.clk(clk), .rst_n(rst_n),
    .conversion_start_n(if1.conversion_start_n), .cs_n(if1.cs_n), .rd_n(if1.rd_n),
    .ch_sel(if1.ch_sel), .eoc_n(if1.eoc_n), .busy(if1.busy), .data_oe(if1.data_oe));
  task automatic summarize();
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_up(input string name);
    check(name, 16'h0000, 16'h0001);
    summarize();
  endtask : give_up
  task automatic host_seq(input logic [3:0] mask);
    int      base;
    int      n;
    int      k;
    sample_t exp [$];
    base = eocs1;
    n = 0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (mask[i]) exp.push_back(ana1[i]);
    end
    for (k = 0; k < 500 && start_ready !== 1'b1; k++) @(negedge clk);
    if (start_ready !== 1'b1) give_up("start_ready");
    start_req = 1'b1;
    ch_mask = mask;
    @(negedge clk);
    start_req = 1'b0;
    for (k = 0; k < 10 && hold1 !== 1'b1; k++) @(negedge clk);
    check("hold", 16'(hold1), 16'h1);
    // Inputs moved after hold must not reach the results
    ana1 = '{12'h000, 12'h000, 12'h000, 12'h000};
    for (k = 0; k < 3000 && seq_done !== 1'b1; k++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) begin
        check("word", 16'(rd_data), 16'((n < exp.size()) ? exp[n] : 12'hFFF));
        n++;
      end
    end
    if (seq_done !== 1'b1) give_up("seq_done");
    check("words", 16'(n), 16'($countones(mask)));
    check("eoc count", 16'(eocs1 - base), 16'($countones(mask)));
    check("busy end", 16'(if1.busy), 16'h0);
    check("hold end", 16'(hold1), 16'h0);
    ana1 = '{12'h111, 12'h222, 12'h333, 12'h444};
  endtask : host_seq
  task automatic pulse_start();
    if2.conversion_start_n = 1'b0;
    repeat (4) @(negedge clk);
    if2.conversion_start_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : pulse_start
  task automatic read2(input sample_t exp);
    if2.cs_n = 1'b0;
    if2.rd_n = 1'b0;
    repeat (6) @(negedge clk);
    check("bus word", 16'(if2.data), 16'(exp));
    if2.cs_n = 1'b1;
    if2.rd_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : read2
  task automatic dev_direct();
    int base;
    int k;
    check("sw reset", 16'(sel2), 16'h000F);
    check("sw idle", 16'(sel1), 16'h000F);
    pulse_start();
    repeat (20) @(negedge clk);
    check("empty set", 16'(if2.busy), 16'h0);
    sw_data = 4'h5;
    sw_we = 1'b1;
    @(negedge clk);
    sw_we = 1'b0;
    sw_mode = 1'b1;
    if2.ch_sel = 4'hA;
    check("sw write", 16'(sel2), 16'h0005);
    base = eocs2;
    pulse_start();
    for (k = 0; k < 200 && eocs2 == base; k++) @(negedge clk);
    if (eocs2 == base) give_up("first eoc");
    // Second start lands while busy and must not restart the sequence
    pulse_start();
    read2(ana2[0]);
    for (k = 0; k < 400 && if2.busy !== 1'b0; k++) @(negedge clk);
    if (if2.busy !== 1'b0) give_up("busy2");
    check("hold2 end", 16'(hold2), 16'h0);
    check("sw count", 16'(eocs2 - base), 16'h2);
    repeat (20) @(negedge clk);
    check("no restart", 16'(if2.busy), 16'h0);
    read2(ana2[2]);
  endtask : dev_direct
  initial begin
    ana1 = '{12'h111, 12'h222, 12'h333, 12'h444};
    ana2 = '{12'hA01, 12'hB02, 12'hC03, 12'hD04};
    if2.conversion_start_n = 1'b1;
    if2.cs_n = 1'b1;
    if2.rd_n = 1'b1;
    if2.ch_sel = 4'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    for (int m = 1; m < 16; m++) begin
      host_seq(4'(m));
    end
    dev_direct();
    summarize();
  end
endmodule : tb_top
